/* rtl/rsq_pkg.sv */
// Purpose: constants for the reset flag and release sequencer
// Assumes: 25 MHz sys_clk
// Notes:   times in ns, cycle counts derived from them
package rsq_pkg;
  localparam int CLK_NS = 40;
  localparam int POR_DELAY_NS = 10000;
  localparam int STARTUP_REG_NS = 20000;
  localparam int STARTUP_POWER_UP_TIMER_NS = 64000000;
  localparam int RST_TIME_NS = 20000;
  localparam int LOCK_NS = 20000;
  localparam int MON_DELAY_NS = 100000;
  localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_REG_CYC = (STARTUP_REG_NS + CLK_NS - 1) / CLK_NS;
  localparam int STARTUP_POWER_UP_TIMER_CYC = (STARTUP_POWER_UP_TIMER_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_TIME_CYC = (RST_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CYC = (LOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int MON_DELAY_CYC = (MON_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int OSC_PERIODS = 1024;
  localparam int OSC_CNT_W = 10;
  localparam int CNT_W = 24;

  localparam logic [7:0] ADDR_CAUSE = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  localparam int B_POR = 0;
  localparam int B_BOR = 1;
  localparam int B_IDLE = 2;
  localparam int B_SLEEP = 3;
  localparam int B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int B_SOFTWARE_WATCHDOG_ENABLE = 5;
  localparam int B_SWRST = 6;
  localparam int B_EXT = 7;
  localparam int B_VREG = 8;
  localparam int B_ILL = 14;
  localparam int B_TRAP = 15;
  localparam logic [15:0] CAUSE_IMPL = 16'hc1ff;
  localparam logic [15:0] CAUSE_POR_VAL = 16'h0003;

  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRCPLL = 3'h1;
  localparam logic [2:0] SRC_XT = 3'h2;
  localparam logic [2:0] SRC_XTPLL = 3'h3;
  localparam logic [2:0] SRC_SOSC = 3'h4;
  localparam logic [2:0] SRC_EC = 3'h5;
  localparam logic [2:0] SRC_ECPLL = 3'h6;
  localparam logic [2:0] SRC_LPRC = 3'h7;

  typedef enum logic [1:0] {RSQ_HOLD, RSQ_RUN} rsq_rst_t;
endpackage

/* rtl/rsq_reset_seq.sv */
// Purpose: reset cause flags, clock source pick and release timing
// Assumes: all event inputs are one-cycle pulses on sys_clk
// Notes:   register port: read data valid one cycle after readStb
//
// Summary of operation
// - any reset source asserts master system reset
// - power-on clears all flags except power-on and brown-out
// - power-on flag by POR; brown-out flag by both
// - event flags set; cleared by power-on, and by brown-out except pin flag
// - watchdog flag cleared by power-save, POR, BOR
// - software writes flags, never causing reset
// - fuse at one forces watchdog enabled
// - POR/BOR use fuse, others current oscillator
// - no clock switching: fuses for every reset
// - POR/BOR hold is power-on+startup+internal delay
// - startup 20us regulator, 64ms otherwise
// - startup on wake only with regulator
// - other resets hold internal delay only
// - crystal sources count 1024 oscillator periods
// - PLL sources add lock wait after count
// - oscillator waits run alongside reset delays
// - execution waits for released clock
// - monitor delay after POR/BOR for crystal/PLL
// - failed clock at monitor start: INTERNAL_FAST_RC_OSC, trap
module rsq_reset_seq #(
  parameter int POWER_UP_TIMER_CYC = rsq_pkg::STARTUP_POWER_UP_TIMER_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        porEvt,
  input  wire logic        borEvt,
  input  wire logic        mclrEvt,
  input  wire logic        swRstEvt,
  input  wire logic        wdtEvt,
  input  wire logic        trapEvt,
  input  wire logic        illEvt,
  input  wire logic        sleepEvt,
  input  wire logic        idleEvt,
  input  wire logic        wakeEvt,
  input  wire logic        regulatorEn,
  input  wire logic        clkSwitchEn,
  input  wire logic        monitorEn,
  input  wire logic        watchdogEnableFuse,
  input  wire logic [2:0]  oscillatorSelectFuse,
  input  wire logic [2:0]  currentOscillatorField,
  input  wire logic        oscTick,
  input  wire logic        clockValid,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [15:0] regRdata,
  output logic             masterSystemReset,
  output logic             sysResetHold,
  output logic             clockReleased,
  output logic             cpuRun,
  output logic      [2:0]  clockSource,
  output logic             watchdogEnabled,
  output logic             monitorActive,
  output logic             oscFailTrap
);
  import rsq_pkg::*;

  // ------------------------------
  // reset sources
  // ------------------------------
  logic anyRst;
  logic pwrRst;
  logic [15:0] cause;
  logic [CNT_W-1:0] rstCnt;
  logic [CNT_W-1:0] wakeCnt;
  logic [OSC_CNT_W:0] oscCnt;
  logic [CNT_W-1:0] lockCnt;
  logic [CNT_W-1:0] monCnt;
  logic porSeq;
  logic monPending;
  logic needOst;
  logic needPll;
  logic [2:0] srcSel;
  rsq_rst_t rstState;

  assign pwrRst = porEvt | borEvt;
  assign anyRst = pwrRst | mclrEvt | swRstEvt | wdtEvt | trapEvt | illEvt;

  function automatic logic [CNT_W-1:0] holdCycles(input logic isPor, input logic reg_on);
    if (isPor) begin
      if (reg_on) begin
        holdCycles = CNT_W'(POR_DELAY_CYC + STARTUP_REG_CYC + RST_TIME_CYC);
      end else begin
        holdCycles = CNT_W'(POR_DELAY_CYC + POWER_UP_TIMER_CYC + RST_TIME_CYC);
      end
    end else begin
      holdCycles = CNT_W'(RST_TIME_CYC);
    end
  endfunction

  // ------------------------------
  // cause flags
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cause <= CAUSE_POR_VAL;
    end else begin
      logic [15:0] nxt;
      nxt = cause;
      if (regWrStb && regAddr == ADDR_CAUSE) begin
        nxt = regWdata & CAUSE_IMPL;
      end
      if (porEvt) begin
        nxt = '0;
        nxt[B_POR] = 1'b1;
      end else if (borEvt) begin
        nxt[B_TRAP] = 1'b0;
        nxt[B_ILL] = 1'b0;
        nxt[B_SWRST] = 1'b0;
        nxt[B_SLEEP] = 1'b0;
        nxt[B_IDLE] = 1'b0;
        nxt[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
      if (sleepEvt || idleEvt) begin
        nxt[B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
      // events win over clears in the same cycle
      if (pwrRst) nxt[B_BOR] = 1'b1;
      if (trapEvt) nxt[B_TRAP] = 1'b1;
      if (illEvt) nxt[B_ILL] = 1'b1;
      if (mclrEvt) nxt[B_EXT] = 1'b1;
      if (swRstEvt) nxt[B_SWRST] = 1'b1;
      if (sleepEvt) nxt[B_SLEEP] = 1'b1;
      if (idleEvt) nxt[B_IDLE] = 1'b1;
      if (wdtEvt) nxt[B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
      cause <= nxt;
    end
  end

  assign watchdogEnabled = watchdogEnableFuse | cause[B_SOFTWARE_WATCHDOG_ENABLE];

  // ------------------------------
  // register read port
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      regRdata <= '0;
    end else if (regRdStb) begin
      unique case (regAddr)
        ADDR_CAUSE:  regRdata <= cause;
        ADDR_STATUS: regRdata <= {8'h00, oscFailTrap, monitorActive, cpuRun, clockReleased,
                                  sysResetHold, clockSource};
        default:     regRdata <= '0;
      endcase
    end else begin
      regRdata <= '0;
    end
  end

  // ------------------------------
  // clock source pick
  // ------------------------------
  always_comb begin
    if (!clkSwitchEn || pwrRst) begin
      srcSel = oscillatorSelectFuse;
    end else begin
      srcSel = currentOscillatorField;
    end
  end
  assign needOst = (clockSource == SRC_XT) || (clockSource == SRC_XTPLL) || (clockSource == SRC_SOSC);
  assign needPll = (clockSource == SRC_FRCPLL) || (clockSource == SRC_XTPLL) || (clockSource == SRC_ECPLL);

  // ------------------------------
  // system reset hold timer
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rstState <= RSQ_HOLD;
      rstCnt <= holdCycles(1'b1, 1'b1);
      porSeq <= 1'b1;
      clockSource <= SRC_FRC;
    end else if (anyRst) begin
      rstState <= RSQ_HOLD;
      rstCnt <= holdCycles(pwrRst, regulatorEn);
      porSeq <= pwrRst;
      clockSource <= srcSel;
    end else if (monitorActive && !clockValid && monitorEn) begin
      clockSource <= SRC_FRC;
    end else begin
      unique case (rstState)
        RSQ_HOLD: begin
          if (rstCnt <= CNT_W'(1)) rstState <= RSQ_RUN;
          else rstCnt <= rstCnt - CNT_W'(1);
        end
        RSQ_RUN: ;
      endcase
    end
  end
  assign sysResetHold = (rstState == RSQ_HOLD);
  assign masterSystemReset = anyRst | sysResetHold;

  // wake from power-down: start-up delay only with the regulator on
  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      wakeCnt <= '0;
    end else if (wakeEvt && regulatorEn) begin
      wakeCnt <= CNT_W'(STARTUP_REG_CYC);
    end else if (wakeCnt != '0) begin
      wakeCnt <= wakeCnt - CNT_W'(1);
    end
  end

  // ------------------------------
  // oscillator start-up and lock, run beside the hold timer
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      oscCnt <= '0;
    end else if (needOst && oscTick && oscCnt < (OSC_CNT_W+1)'(OSC_PERIODS)) begin
      oscCnt <= oscCnt + (OSC_CNT_W+1)'(1);
    end
  end

  logic ostDone;
  assign ostDone = !needOst || oscCnt == (OSC_CNT_W+1)'(OSC_PERIODS);

  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      lockCnt <= '0;
    end else if (needPll && ostDone && lockCnt < CNT_W'(LOCK_CYC)) begin
      lockCnt <= lockCnt + CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      clockReleased <= 1'b0;
    end else begin
      clockReleased <= ostDone && (!needPll || lockCnt == CNT_W'(LOCK_CYC));
    end
  end

  assign cpuRun = !sysResetHold && clockReleased && wakeCnt == '0;

  // ------------------------------
  // clock failure monitor start
  // ------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      monCnt <= '0;
      monPending <= 1'b0;
      monitorActive <= 1'b0;
    end else if (rstState == RSQ_HOLD && rstCnt <= CNT_W'(1)) begin
      monPending <= porSeq && (needOst || needPll);
      monCnt <= CNT_W'(MON_DELAY_CYC);
      monitorActive <= monitorEn && !(porSeq && (needOst || needPll));
    end else if (monPending) begin
      if (monCnt <= CNT_W'(1)) begin
        monPending <= 1'b0;
        monitorActive <= monitorEn;
      end else begin
        monCnt <= monCnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || anyRst) begin
      oscFailTrap <= 1'b0;
    end else if (monitorActive && monitorEn && !clockValid) begin
      oscFailTrap <= 1'b1;
    end
  end

  // ------------------------------
  // checks
  // ------------------------------
  por_flags_a: assert property (@(posedge sys_clk) disable iff (srst)
    porEvt |=> cause[B_POR] && cause[B_BOR] && !cause[B_EXT]) else $error("power-on flags wrong");
  ext_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
    borEvt && !porEvt && cause[B_EXT] && !regWrStb |=> cause[B_EXT]) else $error("brown-out cleared pin flag");
  wdt_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
    sleepEvt && !wdtEvt |=> !cause[B_WATCHDOG_TIMEOUT_FLAG]) else $error("watchdog flag not cleared");
  sw_noreset_a: assert property (@(posedge sys_clk) disable iff (srst)
    regWrStb && !anyRst && !sysResetHold |=> !sysResetHold) else $error("write caused reset");
  wdt_fuse_a: assert property (@(posedge sys_clk) disable iff (srst)
    watchdogEnableFuse |-> watchdogEnabled) else $error("watchdog not forced on");
  src_pick_a: assert property (@(posedge sys_clk) disable iff (srst)
    mclrEvt && !pwrRst && clkSwitchEn |=> clockSource == $past(currentOscillatorField)) else $error("bad source");
  short_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
    mclrEvt && !pwrRst ##1 !anyRst [*8] |-> sysResetHold) else $error("hold ended early");
  any_rst_a: assert property (@(posedge sys_clk) disable iff (srst)
    anyRst |-> masterSystemReset) else $error("reset not asserted");
  run_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    cpuRun |-> clockReleased && !sysResetHold) else $error("ran without clock");
endmodule

/* testbench/rsq_reset_seq_tb_top.sv */
// Purpose: self-checking bench for the reset flag and release sequencer
// Assumes: register port answers one cycle after the read strobe
// Notes:   power-up timer shortened to 50 cycles
module rsq_reset_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rsq_pkg::*;
  localparam int POWER_UP_TIMER = 50;
  logic        sys_clk, srst, wakeEvt, regulatorEn, clkSwitchEn, monitorEn, wdFuse, oscTick, clockValid, tickOn;
  logic [8:0]  evt;
  logic [2:0]  oscSel, curOsc, clockSource;
  logic [7:0]  regAddr;
  logic [15:0] regWdata, regRdata, d;
  logic        regWrStb, regRdStb, masterSystemReset, sysResetHold, clockReleased, cpuRun;
  logic        watchdogEnabled, monitorActive, oscFailTrap, bad;
  int          errors, checks_done, n, rel, mon;
  logic [15:0] evBit [2:8] = '{16'h0080, 16'h0040, 16'h0010, 16'h8000, 16'h4000, 16'h0008, 16'h0004};

  rsq_reset_seq #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER)) u_dut (.sys_clk(sys_clk), .srst(srst), .porEvt(evt[0]), .borEvt(evt[1]),
    .mclrEvt(evt[2]), .swRstEvt(evt[3]), .wdtEvt(evt[4]), .trapEvt(evt[5]), .illEvt(evt[6]),
    .sleepEvt(evt[7]), .idleEvt(evt[8]), .wakeEvt(wakeEvt), .regulatorEn(regulatorEn),
    .clkSwitchEn(clkSwitchEn), .monitorEn(monitorEn), .watchdogEnableFuse(wdFuse),
    .oscillatorSelectFuse(oscSel), .currentOscillatorField(curOsc), .oscTick(oscTick),
    .clockValid(clockValid), .regAddr(regAddr), .regWdata(regWdata), .regWrStb(regWrStb),
    .regRdStb(regRdStb), .regRdata(regRdata), .masterSystemReset(masterSystemReset),
    .sysResetHold(sysResetHold), .clockReleased(clockReleased), .cpuRun(cpuRun),
    .clockSource(clockSource), .watchdogEnabled(watchdogEnabled), .monitorActive(monitorActive),
    .oscFailTrap(oscFailTrap));

  initial begin
    sys_clk = 0;
    forever #20 sys_clk = ~sys_clk;
  end

  // one-cycle pulse every second cycle stands in for the oscillator
  always @(posedge sys_clk) oscTick <= tickOn & ~oscTick;

  // ---------------------------------------------------------------
  // access and compare tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= v;
    regWrStb <= 1'b1;
    @(posedge sys_clk);
    regWrStb <= 1'b0;
    // let the written flags settle before anyone looks at them
    @(negedge sys_clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge sys_clk);
    regRdStb <= 1'b0;
    @(negedge sys_clk);
    check(regRdata, exp);
  endtask

  // pulse one event, then count cycles of held reset
  task automatic pulse(input int i);
    @(posedge sys_clk);
    evt <= 9'h001 << i;
    @(negedge sys_clk);
    check({15'h0, masterSystemReset}, {15'h0, i < 7});
    @(posedge sys_clk);
    evt <= 9'h000;
    n = 0;
    @(negedge sys_clk);
    while (sysResetHold === 1'b1 && n < 100000) begin
      n++;
      @(negedge sys_clk);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #(40 * 50000);
    errors++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    {srst, wakeEvt, monitorEn, wdFuse, tickOn, regWrStb, regRdStb, oscTick} = 8'hff;
    {wakeEvt, monitorEn, wdFuse, tickOn, regWrStb, regRdStb, oscTick} = 7'h00;
    {regulatorEn, clkSwitchEn, clockValid} = 3'b111;
    evt = 9'h000;
    oscSel = SRC_FRC;
    curOsc = SRC_FRC;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    errors = 0;
    checks_done = 0;
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    rdchk(ADDR_CAUSE, CAUSE_POR_VAL);
    // the power-on hold from reset must run out before a write can show no reset
    while (sysResetHold !== 1'b0) @(negedge sys_clk);
    wr(ADDR_CAUSE, 16'hffff);
    check({15'h0, masterSystemReset}, 16'h0000);
    rdchk(ADDR_CAUSE, CAUSE_IMPL);
    wr(8'h08, 16'h0000);
    rdchk(8'h08, 16'h0000);
    rdchk(ADDR_CAUSE, CAUSE_IMPL);
    $display("test software access done");
    for (int i = 2; i <= 8; i++) begin
      wr(ADDR_CAUSE, 16'h0000);
      pulse(i);
      check(16'(n), (i < 7) ? 16'(RST_TIME_CYC) : 16'h0);
      rdchk(ADDR_CAUSE, evBit[i]);
    end
    wr(ADDR_CAUSE, 16'h0010);
    pulse(8);
    rdchk(ADDR_CAUSE, 16'h0004);
    wr(ADDR_CAUSE, 16'hc0dc);
    pulse(1);
    rdchk(ADDR_CAUSE, 16'h0082);
    wr(ADDR_CAUSE, 16'hc0dc);
    pulse(0);
    check(16'(n), 16'(POR_DELAY_CYC + STARTUP_REG_CYC + RST_TIME_CYC));
    rdchk(ADDR_CAUSE, CAUSE_POR_VAL);
    regulatorEn <= 1'b0;
    pulse(0);
    check(16'(n), 16'(POR_DELAY_CYC + POWER_UP_TIMER + RST_TIME_CYC));
    regulatorEn <= 1'b1;
    $display("test flags and hold times done");
    wdFuse <= 1'b1;
    wr(ADDR_CAUSE, 16'h0000);
    check({15'h0, watchdogEnabled}, 16'h0001);
    wdFuse <= 1'b0;
    wr(ADDR_CAUSE, 16'h0000);
    check({15'h0, watchdogEnabled}, 16'h0000);
    wr(ADDR_CAUSE, 16'h0020);
    check({15'h0, watchdogEnabled}, 16'h0001);
    @(posedge sys_clk);
    wakeEvt <= 1'b1;
    @(posedge sys_clk);
    wakeEvt <= 1'b0;
    n = 0;
    @(negedge sys_clk);
    while (cpuRun === 1'b0 && n < 1000) begin
      n++;
      @(negedge sys_clk);
    end
    check(16'(n), 16'(STARTUP_REG_CYC));
    oscSel <= SRC_EC;
    curOsc <= SRC_LPRC;
    for (int k = 0; k < 5; k++) begin
      clkSwitchEn <= (k != 4);
      pulse((k == 4) ? 3 : ((k == 1) ? 0 : ((k == 3) ? 1 : ((k == 2) ? 4 : 2))));
      check({13'h0, clockSource}, {13'h0, (k == 1 || k >= 3) ? SRC_EC : SRC_LPRC});
    end
    $display("test watchdog and clock pick done");
    clkSwitchEn <= 1'b1;
    monitorEn <= 1'b1;
    tickOn <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      oscSel <= (k == 0) ? SRC_XT : SRC_XTPLL;
      clockValid <= (k == 0);
      @(posedge sys_clk);
      evt <= 9'h001;
      @(posedge sys_clk);
      evt <= 9'h000;
      {n, rel, mon, bad} = 0;
      while (mon == 0 && n < 6000) begin
        @(negedge sys_clk);
        n++;
        if (clockReleased === 1'b1 && rel == 0) rel = n;
        if (monitorActive === 1'b1 && mon == 0) mon = n;
        if (cpuRun === 1'b1 && clockReleased !== 1'b1) bad = 1'b1;
      end
      check({15'h0, rel > 2000 + 500 * k && rel < 2200 + 500 * k}, 16'h0001);
      check({15'h0, bad}, 16'h0000);
      check({15'h0, mon > 3700 && mon < 3800}, 16'h0001);
      repeat (4) @(negedge sys_clk);
      check({15'h0, oscFailTrap}, {15'h0, k == 1});
      check({13'h0, clockSource}, {13'h0, (k == 0) ? SRC_XT : SRC_FRC});
    end
    $display("test start-up and monitor done");
    end_sim();
  end
endmodule
